/* File: verilog/swire_pkg.sv */
package swire_pkg;

	// ----------------------------------------
	// Clock and time conversion
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	// Least time, rounded up, at least one cycle
	function automatic int ns_up(int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	// Longest time, rounded down, at least one cycle
	function automatic int ns_dn(int ns);
		int c;
		c = ns / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// ----------------------------------------
	// Wire timing
	// ----------------------------------------
	localparam int T_START_NS = 5;
	localparam int START_CYC = ns_up(T_START_NS);
	localparam int T_BREAK_US = 190;
	localparam int BREAK_CYC = ns_up(T_BREAK_US * 1000);
	localparam int T_HW1_MAX_US = 50;
	localparam int T_HW0_MIN_US = 92;
	localparam int SPLIT_CYC = ns_dn((T_HW1_MAX_US + T_HW0_MIN_US) * 500);
	localparam int T_RESP_MIN_US = 190;
	localparam int T_RESP_MAX_US = 320;
	localparam int T_RESP_US = 200;
	localparam int RESP_MIN_CYC = ns_up(T_RESP_MIN_US * 1000);
	localparam int RESP_MAX_CYC = ns_dn(T_RESP_MAX_US * 1000);
	localparam int RESP_CYC = ns_up(T_RESP_US * 1000);
	localparam int T_DW1_US = 40;
	localparam int T_DW0_US = 112;
	localparam int T_DWIN_US = 220;
	localparam int TX_ONE_CYC = ns_up(T_DW1_US * 1000);
	localparam int TX_ZERO_CYC = ns_up(T_DW0_US * 1000);
	localparam int TX_WIN_CYC = ns_up(T_DWIN_US * 1000);

	// ----------------------------------------
	// Flash timing and memory size
	// ----------------------------------------
	localparam int T_PROG_SETUP_US = 60;
	localparam int T_PROG_BYTE_US = 30;
	localparam int T_PROG_MAX_US = 1020;
	localparam int PROG_SETUP_CYC = ns_dn(T_PROG_SETUP_US * 1000);
	localparam int PROG_BYTE_CYC = ns_dn(T_PROG_BYTE_US * 1000);
	localparam int PROG_MAX_CYC = ns_dn(T_PROG_MAX_US * 1000);
	localparam int MEM_AW = 5;
	localparam int MEM_BYTES = 32;
	localparam int TMR_W = 16;
	localparam int CNT_NUM = 5;

	// ----------------------------------------
	// Wire address map, fields and reset values
	// ----------------------------------------
	localparam logic [6:0] ADDR_FLASH = 7'h20;
	localparam logic [6:0] ADDR_CMD = 7'h40;
	localparam logic [6:0] ADDR_CNT_CLR = 7'h41;
	localparam logic [6:0] ADDR_GPIO = 7'h42;
	localparam logic [6:0] ADDR_STATUS = 7'h43;
	localparam int RW_BIT = 7;
	localparam int GPIO_LVL_BIT = 0;
	localparam int GPIO_DIR_BIT = 1;
	localparam logic [1:0] GPIO_RST = 2'h0;
	localparam logic [7:0] CMD_SLEEP = 8'h01;
	localparam logic [7:0] CMD_HWRESET = 8'h02;
	localparam logic [7:0] CMD_PROG = 8'h03;
	localparam logic [7:0] CMD_RECALL = 8'h04;

endpackage

/* File: verilog/swire_rx_if.sv */
// ----------------------------------------
// Receive events from line sampler to core
// ----------------------------------------
interface swire_rx_if;
	logic bit_stb; // One cycle, a data bit ended
	logic bit_val; // Value of that bit
	logic brk_stb; // One cycle, a break ended
	logic edge_stb; // One cycle, any line transition
	modport phy (output bit_stb, bit_val, brk_stb, edge_stb);
	modport core (input bit_stb, bit_val, brk_stb, edge_stb);
endinterface

/* File: verilog/swire_rx.sv */
module swire_rx #(
	parameter int BREAK_CYC = swire_pkg::BREAK_CYC,
	parameter int SPLIT_CYC = swire_pkg::SPLIT_CYC
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic line_in,
	swire_rx_if.phy rx
);

	// ----------------------------------------
	// Synchroniser and low time counter
	// ----------------------------------------
	logic sync1_ff; // First stage, read only by second
	logic sync2_ff; // Safe line level
	logic prev_ff; // Level one cycle before
	logic [swire_pkg::TMR_W-1:0] low_cnt_ff; // Cycles spent low
	logic rise; // Line just released

	assign rise = sync2_ff && !prev_ff;

	// Two flops, then history
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			sync1_ff <= line_in;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	// Every sampled low cycle counts, so no pulse is too short
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			low_cnt_ff <= '0;
		end else if (!sync2_ff) begin
			if (low_cnt_ff != '1) begin
				low_cnt_ff <= low_cnt_ff + 1'b1;
			end
		end else begin
			low_cnt_ff <= '0;
		end
	end

	// ----------------------------------------
	// Classify each low pulse on release
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rx.bit_stb <= 1'b0;
			rx.bit_val <= 1'b0;
			rx.brk_stb <= 1'b0;
			rx.edge_stb <= 1'b0;
		end else begin
			// Short low is one, long low zero, longest a break
			rx.bit_stb <= rise && (low_cnt_ff < swire_pkg::TMR_W'(BREAK_CYC));
			rx.bit_val <= low_cnt_ff < swire_pkg::TMR_W'(SPLIT_CYC);
			rx.brk_stb <= rise && (low_cnt_ff >= swire_pkg::TMR_W'(BREAK_CYC));
			rx.edge_stb <= sync2_ff != prev_ff;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_start;
		@(posedge clk_in) disable iff (rst_in)
		!sync2_ff |=> (low_cnt_ff != '0) ##1 (rx.bit_stb || rx.brk_stb || low_cnt_ff != '0);
	endproperty
	a_start: assert property (p_start) else $error("short low not counted");

endmodule

/* File: verilog/swire_port.sv */
module swire_port #(
	parameter int BREAK_CYC = swire_pkg::BREAK_CYC,
	parameter int SPLIT_CYC = swire_pkg::SPLIT_CYC,
	parameter int RESP_CYC = swire_pkg::RESP_CYC,
	parameter int TX_ONE_CYC = swire_pkg::TX_ONE_CYC,
	parameter int TX_ZERO_CYC = swire_pkg::TX_ZERO_CYC,
	parameter int TX_WIN_CYC = swire_pkg::TX_WIN_CYC,
	parameter int PROG_SETUP_CYC = swire_pkg::PROG_SETUP_CYC,
	parameter int PROG_BYTE_CYC = swire_pkg::PROG_BYTE_CYC
) (
	input wire logic CORE_CLK_IN,
	input wire logic SRST_IN,
	input wire logic LINE_IN,
	output logic LINE_OUT,
	output logic LINE_OE_OUT,
	input wire logic GPIO_IN,
	output logic GPIO_OUT,
	output logic GPIO_OE_OUT,
	output logic SLEEP_OUT,
	output logic [swire_pkg::CNT_NUM-1:0] COUNTER_CLEAR_OUT,
	input wire logic [swire_pkg::CNT_NUM-1:0] COUNTER_CLEAR_DONE_IN
);

	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	typedef enum {ST_IDLE, ST_ADDR, ST_DATA, ST_WAIT, ST_SEND} link_st_t;
	typedef enum {OP_IDLE, OP_PROG, OP_RECALL} flash_op_t;
	localparam int TW = swire_pkg::TMR_W;
	localparam int AW = swire_pkg::MEM_AW;

	link_st_t state_ff; // Link sequence
	flash_op_t op_ff; // Flash engine operation
	logic [7:0] shift_ff; // Incoming byte, LSB first
	logic [2:0] bit_cnt_ff; // Bit index in byte
	logic [6:0] addr_ff; // Address of current access
	logic [TW-1:0] tmr_ff; // Reply delay and bit window timer
	logic [7:0] tx_byte_ff; // Outgoing byte, shifts right
	logic [7:0] ram [swire_pkg::MEM_BYTES]; // Working RAM
	logic [7:0] flash [swire_pkg::MEM_BYTES]; // Non-volatile copy
	logic [TW-1:0] ftmr_ff; // Flash step timer
	logic [AW-1:0] fidx_ff; // Flash byte index
	logic setup_ff; // Flash setup phase
	logic [1:0] gpio_ff; // GPIO level and direction
	logic gpio_s1_ff; // Pin sync, first stage
	logic gpio_s2_ff; // Pin sync, safe level
	logic line_lvl_ff; // Driven level, always low
	logic [7:0] nxt_byte; // Byte with newest bit
	logic [7:0] rd_data; // Reply data for addr_ff
	logic wr_now; // Write completes this cycle
	logic cmd_ok; // Command accepted
	logic hwrst; // Hardware reset command
	logic [1:0] gpio_wr; // Direction and level written
	logic busy; // Flash engine active

	swire_rx_if rx ();

	// Line sampler and pulse classifier
	swire_rx #(
		.BREAK_CYC(BREAK_CYC),
		.SPLIT_CYC(SPLIT_CYC)
	) u_rx (
		.clk_in(CORE_CLK_IN),
		.rst_in(SRST_IN),
		.line_in(LINE_IN),
		.rx(rx)
	);

	// Low time for one outgoing bit
	function automatic logic [TW-1:0] low_len(logic b);
		return b ? TW'(TX_ONE_CYC) : TW'(TX_ZERO_CYC);
	endfunction

	// Write strobe for one address
	function automatic logic wr_hit(logic [6:0] a);
		return wr_now && (addr_ff == a);
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign nxt_byte = {rx.bit_val, shift_ff[7:1]};
	assign wr_now = (state_ff == ST_DATA) && rx.bit_stb && (bit_cnt_ff == 3'h7);
	assign busy = op_ff != OP_IDLE;
	// Commands are writes to a mapped address
	assign cmd_ok = wr_hit(swire_pkg::ADDR_CMD) && !busy;
	assign hwrst = cmd_ok && (nxt_byte == swire_pkg::CMD_HWRESET);
	assign gpio_wr = {nxt_byte[swire_pkg::GPIO_DIR_BIT], nxt_byte[swire_pkg::GPIO_LVL_BIT]};
	assign LINE_OUT = line_lvl_ff;
	assign GPIO_OUT = gpio_ff[swire_pkg::GPIO_LVL_BIT];
	assign GPIO_OE_OUT = gpio_ff[swire_pkg::GPIO_DIR_BIT];

	// Read mux, unmapped reads as zero
	always_comb begin
		rd_data = 8'h00;
		if (addr_ff < swire_pkg::ADDR_FLASH) begin
			rd_data = ram[addr_ff[AW-1:0]];
		end else if (addr_ff < swire_pkg::ADDR_CMD) begin
			rd_data = flash[addr_ff[AW-1:0]];
		end else if (addr_ff == swire_pkg::ADDR_CNT_CLR) begin
			rd_data = 8'(COUNTER_CLEAR_OUT);
		end else if (addr_ff == swire_pkg::ADDR_GPIO) begin
			rd_data = {5'h00, gpio_s2_ff, gpio_ff};
		end else if (addr_ff == swire_pkg::ADDR_STATUS) begin
			rd_data = {6'h00, SLEEP_OUT, busy};
		end
	end

	// ----------------------------------------
	// Link sequencer
	// ----------------------------------------
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			state_ff <= ST_IDLE;
			shift_ff <= 8'h00;
			bit_cnt_ff <= 3'h0;
			addr_ff <= 7'h00;
			tmr_ff <= '0;
			tx_byte_ff <= 8'h00;
		end else if (rx.brk_stb && state_ff != ST_SEND) begin
			// A break outside a reply restarts the frame
			state_ff <= ST_ADDR;
			bit_cnt_ff <= 3'h0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					state_ff <= ST_IDLE;
				end
				ST_ADDR: if (rx.bit_stb) begin
					shift_ff <= nxt_byte;
					bit_cnt_ff <= bit_cnt_ff + 3'h1;
					if (bit_cnt_ff == 3'h7) begin
						addr_ff <= nxt_byte[6:0];
						tmr_ff <= '0;
						state_ff <= nxt_byte[swire_pkg::RW_BIT] ? ST_DATA : ST_WAIT;
					end
				end
				ST_DATA: if (rx.bit_stb) begin
					shift_ff <= nxt_byte;
					bit_cnt_ff <= bit_cnt_ff + 3'h1;
					if (bit_cnt_ff == 3'h7) begin
						state_ff <= ST_ADDR;
					end
				end
				// Hold off the reply for the response time
				ST_WAIT: begin
					tmr_ff <= tmr_ff + 1'b1;
					if (tmr_ff == TW'(RESP_CYC - 1)) begin
						tmr_ff <= '0;
						bit_cnt_ff <= 3'h0;
						tx_byte_ff <= rd_data;
						state_ff <= ST_SEND;
					end
				end
				// One bit window per bit, LSB first
				ST_SEND: begin
					tmr_ff <= tmr_ff + 1'b1;
					if (tmr_ff == TW'(TX_WIN_CYC - 1)) begin
						tmr_ff <= '0;
						tx_byte_ff <= {1'b0, tx_byte_ff[7:1]};
						bit_cnt_ff <= bit_cnt_ff + 3'h1;
						if (bit_cnt_ff == 3'h7) begin
							state_ff <= ST_ADDR;
						end
					end
				end
			endcase
		end
	end

	// Pull the wire low for the bit's low time
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			LINE_OE_OUT <= 1'b0;
			line_lvl_ff <= 1'b0;
		end else begin
			LINE_OE_OUT <= (state_ff == ST_SEND) && (tmr_ff < low_len(tx_byte_ff[0]));
			line_lvl_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Sleep on command, wake on any edge; set wins
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			SLEEP_OUT <= 1'b0;
		end else if (cmd_ok && nxt_byte == swire_pkg::CMD_SLEEP) begin
			SLEEP_OUT <= 1'b1;
		end else if (rx.edge_stb) begin
			SLEEP_OUT <= 1'b0;
		end
	end

	// Clear bits stay until counter reports done; set wins
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			COUNTER_CLEAR_OUT <= '0;
		end else if (hwrst) begin
			COUNTER_CLEAR_OUT <= '1;
		end else begin
			COUNTER_CLEAR_OUT <= (COUNTER_CLEAR_OUT & ~COUNTER_CLEAR_DONE_IN)
				| (wr_hit(swire_pkg::ADDR_CNT_CLR) ? nxt_byte[swire_pkg::CNT_NUM-1:0] : '0);
		end
	end

	// GPIO direction and level from the wire; pin read back synced
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			gpio_ff <= swire_pkg::GPIO_RST;
			gpio_s1_ff <= 1'b0;
			gpio_s2_ff <= 1'b0;
		end else begin
			gpio_s1_ff <= GPIO_IN;
			gpio_s2_ff <= gpio_s1_ff;
			if (hwrst) begin
				gpio_ff <= swire_pkg::GPIO_RST;
			end else if (wr_hit(swire_pkg::ADDR_GPIO)) begin
				gpio_ff <= gpio_wr;
			end
		end
	end

	// ----------------------------------------
	// Flash engine
	// ----------------------------------------
	// Setup time, then one byte per byte time
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			op_ff <= OP_IDLE;
			ftmr_ff <= '0;
			fidx_ff <= '0;
			setup_ff <= 1'b0;
		end else begin
			unique case (op_ff)
				OP_IDLE: begin
					fidx_ff <= '0;
					if (cmd_ok && nxt_byte == swire_pkg::CMD_PROG) begin
						op_ff <= OP_PROG;
						setup_ff <= 1'b1;
						ftmr_ff <= TW'(PROG_SETUP_CYC - 1);
					end else if (cmd_ok && nxt_byte == swire_pkg::CMD_RECALL) begin
						op_ff <= OP_RECALL;
					end
				end
				OP_PROG: if (ftmr_ff != '0) begin
					ftmr_ff <= ftmr_ff - 1'b1;
				end else begin
					ftmr_ff <= TW'(PROG_BYTE_CYC - 1);
					setup_ff <= 1'b0;
					if (!setup_ff) begin
						fidx_ff <= fidx_ff + 1'b1;
						if (fidx_ff == AW'(swire_pkg::MEM_BYTES - 1)) begin
							op_ff <= OP_IDLE;
						end
					end
				end
				OP_RECALL: begin
					fidx_ff <= fidx_ff + 1'b1;
					if (fidx_ff == AW'(swire_pkg::MEM_BYTES - 1)) begin
						op_ff <= OP_IDLE;
					end
				end
			endcase
		end
	end

	// Flash array, written at the end of each byte time
	always_ff @(posedge CORE_CLK_IN) begin
		if (op_ff == OP_PROG && !setup_ff && ftmr_ff == '0) begin
			flash[fidx_ff] <= ram[fidx_ff];
		end
	end

	// RAM: host writes while idle, recall copies flash
	always_ff @(posedge CORE_CLK_IN) begin
		if (op_ff == OP_RECALL) begin
			ram[fidx_ff] <= flash[fidx_ff];
		end else if (wr_now && !busy && addr_ff < swire_pkg::ADDR_FLASH) begin
			ram[addr_ff[AW-1:0]] <= nxt_byte;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [TW-1:0] resp_cnt_ff; // Cycles from request end to reply
	logic [TW-1:0] oe_len_ff; // Cycles of current low drive
	logic [TW-1:0] prog_cnt_ff; // Cycles of current program

	// Helper counters for timing checks
	always_ff @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			resp_cnt_ff <= '0;
			oe_len_ff <= '0;
			prog_cnt_ff <= '0;
		end else begin
			resp_cnt_ff <= (state_ff == ST_WAIT || (state_ff == ST_SEND && bit_cnt_ff == 3'h0
				&& !LINE_OE_OUT)) ? resp_cnt_ff + 1'b1 : '0;
			oe_len_ff <= LINE_OE_OUT ? oe_len_ff + 1'b1 : '0;
			prog_cnt_ff <= (op_ff == OP_PROG) ? prog_cnt_ff + 1'b1 : '0;
		end
	end

	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (SRST_IN);

	property p_resp;
		$rose(LINE_OE_OUT) && bit_cnt_ff == 3'h0 |-> resp_cnt_ff == TW'(RESP_CYC + 1);
	endproperty
	a_resp: assert property (p_resp) else $error("reply delay wrong");
	property p_txlen;
		$fell(LINE_OE_OUT) |-> oe_len_ff == low_len(tx_byte_ff[0]);
	endproperty
	a_txlen: assert property (p_txlen) else $error("bit low time wrong");
	property p_drive;
		LINE_OE_OUT |-> state_ff == ST_SEND && LINE_OUT == 1'b0;
	endproperty
	a_drive: assert property (p_drive) else $error("wire driven outside reply");
	property p_sleep;
		cmd_ok && nxt_byte == swire_pkg::CMD_SLEEP |=> SLEEP_OUT;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	property p_hwrst;
		hwrst |=> &COUNTER_CLEAR_OUT && gpio_ff == swire_pkg::GPIO_RST;
	endproperty
	a_hwrst: assert property (p_hwrst) else $error("hardware reset missed");
	property p_wake;
		SLEEP_OUT && rx.edge_stb && !cmd_ok |=> !SLEEP_OUT;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on edge");
	property p_clr;
		COUNTER_CLEAR_OUT[0] && !hwrst && !wr_hit(swire_pkg::ADDR_CNT_CLR)
			|=> COUNTER_CLEAR_OUT[0] == !$past(COUNTER_CLEAR_DONE_IN[0]);
	endproperty
	a_clr: assert property (p_clr) else $error("clear bit wrong");
	property p_prog;
		op_ff == OP_PROG |-> prog_cnt_ff < TW'(swire_pkg::PROG_MAX_CYC);
	endproperty
	a_prog: assert property (p_prog) else $error("program too long");
	property p_recall;
		cmd_ok && nxt_byte == swire_pkg::CMD_RECALL |=> op_ff == OP_RECALL [*8];
	endproperty
	a_recall: assert property (p_recall) else $error("recall not started");
	property p_gpio;
		wr_hit(swire_pkg::ADDR_GPIO) && !hwrst |=> {GPIO_OE_OUT, GPIO_OUT} == $past(gpio_wr);
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio write lost");

	c_reply: cover property ($fell(LINE_OE_OUT) && bit_cnt_ff == 3'h7);
	c_prog: cover property ($fell(op_ff == OP_PROG));
	c_wake: cover property ($fell(SLEEP_OUT));

endmodule

/* File: sim/swire_host.sv */
// ----------------------------------------
// Host side of the single wire, pulled up
// ----------------------------------------
module swire_host #(
	parameter int ONE_LOW = 1,
	parameter int ZERO_LOW = 12,
	parameter int BRK_LOW = 7700,
	parameter int GAP = 6,
	parameter int SPLIT = 8,
	parameter int TAIL = 24
) (
	input wire logic clk_in,
	input wire logic wire_in,
	output logic low_out
);
	timeunit 1ns;
	timeprecision 100ps;

	// Wire released until the first request
	initial begin
		low_out = 1'b0;
	end

	// One clean low pulse, no glitches, then release
	task automatic pulse(input int n);
		@(posedge clk_in);
		low_out <= 1'b1;
		repeat (n) @(posedge clk_in);
		low_out <= 1'b0;
		repeat (GAP) @(posedge clk_in);
	endtask

	// Long low opens a frame
	task automatic send_break();
		pulse(BRK_LOW);
	endtask

	// LSB first; a one is a single-cycle low
	task automatic send_byte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			pulse(b[i] ? ONE_LOW : ZERO_LOW);
		end
	endtask

	// Delay to first device pulse, then eight pulses decoded by length
	task automatic read_byte(output logic [7:0] b, output int lat, output logic ok);
		int cnt;
		int lim;
		ok = 1'b1;
		lat = 0;
		b = 8'h00;
		for (int i = 0; i < 8; i++) begin
			cnt = 0;
			// First bit may come as late as the longest response time
			lim = (i == 0) ? swire_pkg::RESP_MAX_CYC : 400;
			@(negedge clk_in);
			// Wait for the device to pull low
			while (wire_in !== 1'b0 && cnt < lim) begin
				cnt++;
				@(negedge clk_in);
			end
			if (i == 0) begin
				lat = GAP + cnt;
			end
			if (cnt >= lim) begin
				ok = 1'b0;
			end
			cnt = 0;
			// Length of the low decides the bit
			while (wire_in === 1'b0 && cnt < 400) begin
				cnt++;
				@(negedge clk_in);
			end
			if (cnt >= 400) begin
				ok = 1'b0;
			end
			b[i] = (cnt < SPLIT);
		end
		repeat (TAIL) @(negedge clk_in);
	endtask
endmodule

/* File: sim/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Shortened timing
	// ----------------------------------------
	localparam int RX_SPLIT = 8; // Host one is 1 cycle low, host zero 12
	localparam int ONE = 4;
	localparam int ZERO = 12;
	localparam int WIN = 20;
	localparam int PBYTE = 2;

	logic clk = 1'b0; // Core clock
	logic srst = 1'b1; // Synchronous reset
	logic host_low; // Host pulls the wire
	logic line_oe; // Device pulls the wire
	logic line_out; // Device drive level
	logic gpio_out; // GPIO drive level
	logic gpio_oe; // GPIO drive enable
	logic gpio_pin; // Resolved GPIO pin
	logic sleep; // Sleep flag
	logic wire_lvl; // Resolved wire, pulled up
	logic [swire_pkg::CNT_NUM-1:0] clr; // Counter clear requests
	logic [swire_pkg::CNT_NUM-1:0] clr_done = '0; // Counter acknowledges
	int miscompares = 0;
	int n_checks = 0;

	assign wire_lvl = !(line_oe | host_low);
	// Pin pulled down when not driven
	assign gpio_pin = gpio_oe ? gpio_out : 1'b0;

	// Clock, 25 ns period
	always #12.5 clk = ~clk;

	// Counter logic acknowledges a clear one cycle later
	always @(posedge clk) begin
		clr_done <= clr;
	end

	swire_host host (
		.clk_in(clk),
		.wire_in(wire_lvl),
		.low_out(host_low)
	);

	swire_port #(.SPLIT_CYC(RX_SPLIT), .TX_ONE_CYC(ONE), .TX_ZERO_CYC(ZERO),
		.TX_WIN_CYC(WIN), .PROG_BYTE_CYC(PBYTE)) dut (
		.CORE_CLK_IN(clk),
		.SRST_IN(srst),
		.LINE_IN(wire_lvl),
		.LINE_OUT(line_out),
		.LINE_OE_OUT(line_oe),
		.GPIO_IN(gpio_pin),
		.GPIO_OUT(gpio_out),
		.GPIO_OE_OUT(gpio_oe),
		.SLEEP_OUT(sleep),
		.COUNTER_CLEAR_OUT(clr),
		.COUNTER_CLEAR_DONE_IN(clr_done)
	);

	// ----------------------------------------
	// Compare and close
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// All outputs quiet after reset
	task automatic t_reset();
		check({line_oe, line_out, gpio_out, gpio_oe, sleep, clr}, '0);
	endtask

	// Write GPIO control, then read it back in the same frame
	task automatic t_gpio_rw();
		logic [7:0] d;
		int lat;
		logic ok;
		host.send_break();
		host.send_byte({1'b1, swire_pkg::ADDR_GPIO});
		host.send_byte(8'h03);
		check(gpio_out, 1'b1);
		check(gpio_oe, 1'b1);
		host.send_byte({1'b0, swire_pkg::ADDR_GPIO});
		host.read_byte(d, lat, ok);
		if (ok !== 1'b1) begin
			check(ok, 1'b1);
			end_of_test();
		end
		check(d, 8'h07);
		check(lat >= swire_pkg::RESP_MIN_CYC && lat <= swire_pkg::RESP_MAX_CYC, 1'b1);
		check(line_out, 1'b0);
	endtask

	// Hardware reset command clears GPIO and raises every counter clear
	task automatic t_hwrst();
		logic seen;
		seen = 1'b0;
		host.send_byte({1'b1, swire_pkg::ADDR_CMD});
		fork
			host.send_byte(swire_pkg::CMD_HWRESET);
			repeat (200) begin
				@(posedge clk);
				if (clr == '1) begin
					seen = 1'b1;
				end
			end
		join
		check(seen, 1'b1);
		check(clr, '0);
		check({gpio_oe, gpio_out}, 2'h0);
	endtask

	// Store RAM to flash, overwrite RAM, recall flash and read it back
	task automatic t_flash();
		logic [7:0] d;
		int lat;
		logic ok;
		host.send_byte({1'b1, 7'h00});
		host.send_byte(8'ha5);
		host.send_byte({1'b1, swire_pkg::ADDR_CMD});
		host.send_byte(swire_pkg::CMD_PROG);
		// Program must be over within its setup plus one byte time per byte
		repeat (swire_pkg::PROG_SETUP_CYC + swire_pkg::MEM_BYTES * PBYTE) @(posedge clk);
		host.send_byte({1'b1, 7'h00});
		host.send_byte(8'h5a);
		host.send_byte({1'b1, swire_pkg::ADDR_CMD});
		host.send_byte(swire_pkg::CMD_RECALL);
		host.send_byte({1'b0, 7'h00});
		host.read_byte(d, lat, ok);
		check(ok, 1'b1);
		check(d, 8'ha5);
	endtask

	// Sleep after the flash store, then wake on a wire edge
	task automatic t_sleep();
		host.send_byte({1'b1, swire_pkg::ADDR_CMD});
		host.send_byte(swire_pkg::CMD_SLEEP);
		check(sleep, 1'b1);
		check(clr, '0);
		fork
			host.pulse(1);
			begin
				repeat (12) @(posedge clk);
				check(sleep, 1'b0);
			end
		join
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_gpio_rw();
		t_hwrst();
		t_flash();
		t_sleep();
		end_of_test();
	end
endmodule
